/* core/dcb_pkg.sv */
// Package of constants and types for the deserializer configuration block.
package dcb_pkg;

   // Register byte offsets on the AHB-Lite bus.
   localparam logic [7:0] DCB_CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] DCB_STATUS_OFFSET = 8'h04;

   // Control register field positions.
   localparam int DCB_MAP_OVR_BIT    = 0;
   localparam int DCB_MAP_VAL_BIT    = 1;
   localparam int DCB_FILT_OVR_BIT   = 2;
   localparam int DCB_FILT_VAL_BIT   = 3;
   localparam int DCB_SPREAD_OVR_BIT = 4;
   localparam int DCB_SPREAD_LSB     = 5;
   localparam int DCB_EQ_OVR_BIT     = 8;
   localparam int DCB_EQ_VAL_BIT     = 9;
   localparam int DCB_CTRL_WIDTH     = 10;
   localparam logic [DCB_CTRL_WIDTH-1:0] DCB_CTRL_RESET = 10'h000;

   // Status register field positions.
   localparam int DCB_ST_MAP_BIT    = 0;
   localparam int DCB_ST_MODE_LSB   = 1;
   localparam int DCB_ST_FILT_BIT   = 3;
   localparam int DCB_ST_SPREAD_LSB = 4;
   localparam int DCB_ST_EQ_BIT     = 7;
   localparam int DCB_ST_TEST_BIT   = 8;
   localparam int DCB_ST_PASS_BIT   = 9;
   localparam int DCB_ST_ADDR_LSB   = 16;

   // Two-wire bus addresses for the eight divider levels; values arbitrary.
   localparam logic [6:0] DCB_ADDR_BASE = 7'h30;

   // Operating mode pin codes.
   typedef enum logic [1:0]
   {
      DCB_MODE_SAME_UNFILTERED = 2'h0,
      DCB_MODE_SAME_FILTERED   = 2'h1,
      DCB_MODE_LEGACY_FIRST    = 2'h2,
      DCB_MODE_LEGACY_SECOND   = 2'h3
   } dcb_mode_type;

   // Self-test sequencer states.
   typedef enum logic [1:0]
   {
      DCB_TEST_IDLE = 2'b01,
      DCB_TEST_RUN  = 2'b10
   } dcb_test_type;

   // Effective configuration handed to the data path.
   typedef struct packed
   {
      logic         mapMsbFirst;
      dcb_mode_type mode;
      logic         filterOn;
      logic [2:0]   spreadRange;
      logic         eqHighGain;
   } dcb_config_type;

   localparam dcb_config_type DCB_CONFIG_RESET =
      '{1'b0, DCB_MODE_SAME_UNFILTERED, 1'b0, 3'h0, 1'b0};

endpackage

/* core/dcb_deser_config.sv */
// Configuration, self-test and strap control of the link deserializer.
//
// Function
// - With the map select pin high the MSBs go on output lane three.
// - With the map select pin low the LSBs go on output lane three.
// - Mode 00 pairs with a same-generation serializer, filter off.
// - Mode 01 pairs with a same-generation serializer, filter on.
// - Mode 10 uses the first older serializer family's link format.
// - Mode 11 uses the second older serializer family's link format.
// - Mode comes from the pins; registers may override it only partly.
// - A three-bit input selects the spread spectrum range of the clock.
// - The equalizer strap on the pass pin selects high (1) or low gain.
// - Self-test runs while its enable is high, normal work while low.
// - In self-test the pass output is high until any error is seen.
// - The two-wire bus address derives from the divider level pin.
// - The bus clock is input only, data two-way, both only pulled low.
// - Power-down low stops the PLL and resets all control registers.
module dcb_deser_config
(
   input  wire logic                  clock,
   input  wire logic                  srst,
   // AHB-Lite slave.
   input  wire logic                  hsel,
   input  wire logic [7:0]            haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic                  hready,
   input  wire logic [31:0]           hwdata,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // Configuration pins, asynchronous to the clock.
   input  wire logic                  outputBitMapSelect,
   input  wire logic [1:0]            modeSelect,
   input  wire logic [2:0]            spreadRangeSelect,
   input  wire logic                  selfTestEnable,
   input  wire logic                  powerDown_n,
   input  wire logic [2:0]            busAddressSelect,
   // Shared pass output and equalizer strap pin.
   input  wire logic                  passIn,
   output logic                       passOut,
   output logic                       passOe,
   // Two-wire control bus pins.
   input  wire logic                  sclIn,
   input  wire logic                  sdaIn,
   output logic                       sdaOut,
   output logic                       sdaOe,
   output logic                       sclSync,
   output logic                       sdaSync,
   // Same-clock hooks from the data path and the two-wire engine.
   input  wire logic                  testErrorSeen,
   input  wire logic                  sdaPullLow,
   // Results to the data path.
   output dcb_pkg::dcb_config_type    linkConfig,
   output logic                       pllEnable,
   output logic                       selfTestActive,
   output logic [6:0]                 busAddress
);
   import dcb_pkg::*;

   // Maps a divider level code onto a two-wire bus address.
   function automatic logic [6:0] addrFromLevel(input logic [2:0] level);
      addrFromLevel = DCB_ADDR_BASE + {4'h0, level};
   endfunction

   // Two-stage synchronisers; stage one is read by stage two only.
   localparam int SYNC_WIDTH = 14;
   logic [SYNC_WIDTH-1:0] syncStage1;
   logic [SYNC_WIDTH-1:0] syncStage2;
   logic [SYNC_WIDTH-1:0] pinBundle;

   assign pinBundle = {outputBitMapSelect, modeSelect, spreadRangeSelect,
                       selfTestEnable, powerDown_n, busAddressSelect,
                       passIn, sclIn, sdaIn};

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         syncStage1 <= '0;
         syncStage2 <= '0;
      end
      else
      begin
         syncStage1 <= pinBundle;
         syncStage2 <= syncStage1;
      end
   end

   logic         mapPin;
   logic [1:0]   modePin;
   logic [2:0]   spreadPin;
   logic         testPin;
   logic         powerPin;
   logic [2:0]   addrPin;
   logic         passPin;
   logic         sclPin;
   logic         sdaPin;

   assign {mapPin, modePin, spreadPin, testPin, powerPin, addrPin,
           passPin, sclPin, sdaPin} = syncStage2;

   // All but the synchronisers and the AHB-Lite interface is held in its default state while powered down.
   logic blockReset;
   assign blockReset = srst | ~powerPin;

   // AHB-Lite address phase capture; zero wait states always.
   logic       wrPending;
   logic       rdPending;
   logic [7:0] addrHeld;
   logic       next_wrPending;
   logic       next_rdPending;
   logic [7:0] next_addrHeld;
   logic       accept;

   assign accept = hsel & hready & htrans[1];

   always_comb
   begin
      next_wrPending = accept & hwrite;
      next_rdPending = accept & ~hwrite;
      next_addrHeld  = accept ? haddr : addrHeld;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         wrPending <= 1'b0;
         rdPending <= 1'b0;
         addrHeld  <= 8'h00;
      end
      else
      begin
         wrPending <= next_wrPending;
         rdPending <= next_rdPending;
         addrHeld  <= next_addrHeld;
      end
   end

   // Control register holding the override enables and values.
   logic [DCB_CTRL_WIDTH-1:0] ctrl;
   logic [DCB_CTRL_WIDTH-1:0] next_ctrl;

   always_comb
   begin
      next_ctrl = ctrl;
      if (wrPending && addrHeld == DCB_CTRL_OFFSET)
      begin
         next_ctrl = hwdata[DCB_CTRL_WIDTH-1:0];
      end
   end

   always_ff @(posedge clock)
   begin
      if (blockReset)
      begin
         ctrl <= DCB_CTRL_RESET;
      end
      else
      begin
         ctrl <= next_ctrl;
      end
   end

   // Equalizer strap is caught on the first cycle out of power-down,
   // while the pass driver is still off and the pin shows the strap.
   logic eqStrap;
   logic strapTaken;
   logic next_eqStrap;
   logic next_strapTaken;

   always_comb
   begin
      next_strapTaken = 1'b1;
      next_eqStrap    = strapTaken ? eqStrap : passPin;
   end

   always_ff @(posedge clock)
   begin
      if (blockReset)
      begin
         eqStrap    <= 1'b0;
         strapTaken <= 1'b0;
      end
      else
      begin
         eqStrap    <= next_eqStrap;
         strapTaken <= next_strapTaken;
      end
   end

   // Effective configuration: pins unless a register override is on.
   // Only the filter of a same-generation mode may be overridden; the
   // link family itself always follows the pins.
   dcb_config_type next_config;
   logic           sameGen;

   assign sameGen = ~modePin[1];

   always_comb
   begin
      next_config.mapMsbFirst = ctrl[DCB_MAP_OVR_BIT] ?
         ctrl[DCB_MAP_VAL_BIT] : mapPin;
      next_config.mode = dcb_mode_type'(modePin);
      if (sameGen && ctrl[DCB_FILT_OVR_BIT])
      begin
         next_config.filterOn = ctrl[DCB_FILT_VAL_BIT];
      end
      else
      begin
         next_config.filterOn =
            (modePin == DCB_MODE_SAME_FILTERED);
      end
      next_config.spreadRange = ctrl[DCB_SPREAD_OVR_BIT] ?
         ctrl[DCB_SPREAD_LSB +: 3] : spreadPin;
      next_config.eqHighGain = ctrl[DCB_EQ_OVR_BIT] ?
         ctrl[DCB_EQ_VAL_BIT] : eqStrap;
   end

   always_ff @(posedge clock)
   begin
      if (blockReset)
      begin
         linkConfig <= DCB_CONFIG_RESET;
         pllEnable  <= 1'b0;
      end
      else
      begin
         linkConfig <= next_config;
         pllEnable  <= 1'b1;
      end
   end

   // Self-test sequencer with a sticky error flag; a new error in the
   // entry cycle still counts because the set wins over the clear.
   dcb_test_type testState;
   dcb_test_type next_testState;
   logic         errorFlag;
   logic         next_errorFlag;

   always_comb
   begin
      next_testState = testState;
      next_errorFlag = errorFlag;
      unique case (testState)
         DCB_TEST_IDLE:
         begin
            if (testPin)
            begin
               next_testState = DCB_TEST_RUN;
               next_errorFlag = 1'b0;
            end
         end
         DCB_TEST_RUN:
         begin
            if (!testPin)
            begin
               next_testState = DCB_TEST_IDLE;
            end
         end
         default:
         begin
            next_testState = DCB_TEST_IDLE;
         end
      endcase
      if (testErrorSeen && (testPin || testState == DCB_TEST_RUN))
      begin
         next_errorFlag = 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (blockReset)
      begin
         testState <= DCB_TEST_IDLE;
         errorFlag <= 1'b0;
      end
      else
      begin
         testState <= next_testState;
         errorFlag <= next_errorFlag;
      end
   end

   // Pin drivers: pass is driven only in self-test so the strap can be
   // read at other times; the data line is only ever pulled low.
   logic inTest;
   assign inTest = (next_testState == DCB_TEST_RUN);

   always_ff @(posedge clock)
   begin
      if (blockReset)
      begin
         selfTestActive <= 1'b0;
         passOut        <= 1'b0;
         passOe         <= 1'b0;
         sdaOut         <= 1'b0;
         sdaOe          <= 1'b0;
         sclSync        <= 1'b0;
         sdaSync        <= 1'b0;
         busAddress     <= DCB_ADDR_BASE;
      end
      else
      begin
         selfTestActive <= inTest;
         passOut        <= inTest & ~next_errorFlag;
         passOe         <= inTest;
         sdaOut         <= 1'b0;
         sdaOe          <= sdaPullLow;
         sclSync        <= sclPin;
         sdaSync        <= sdaPin;
         busAddress     <= addrFromLevel(addrPin);
      end
   end

   // Read data and response; unmapped addresses read zero with OKAY.
   logic [31:0] next_hrdata;

   always_comb
   begin
      next_hrdata = 32'h0000_0000;
      if (accept && !hwrite)
      begin
         if (haddr == DCB_CTRL_OFFSET)
         begin
            next_hrdata[DCB_CTRL_WIDTH-1:0] = next_ctrl;
         end
         else if (haddr == DCB_STATUS_OFFSET)
         begin
            next_hrdata[DCB_ST_MAP_BIT]            = linkConfig.mapMsbFirst;
            next_hrdata[DCB_ST_MODE_LSB +: 2]      = linkConfig.mode;
            next_hrdata[DCB_ST_FILT_BIT]           = linkConfig.filterOn;
            next_hrdata[DCB_ST_SPREAD_LSB +: 3]    = linkConfig.spreadRange;
            next_hrdata[DCB_ST_EQ_BIT]             = linkConfig.eqHighGain;
            next_hrdata[DCB_ST_TEST_BIT]           = selfTestActive;
            next_hrdata[DCB_ST_PASS_BIT]           = passOut;
            next_hrdata[DCB_ST_ADDR_LSB +: 7]      = busAddress;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hrdata    <= next_hrdata;
         hreadyout <= 1'b1; // Zero wait states: no stall ever needed.
         hresp     <= 1'b0;
      end
   end

endmodule

/* dv/dcb_board_model.sv */
// Board model: strap resistor, two-wire pull-up and link error source.
module dcb_board_model
(
   input  wire logic passOut,
   input  wire logic passOe,
   input  wire logic sdaOut,
   input  wire logic sdaOe,
   input  wire logic strapHigh,
   input  wire logic linkError,
   output logic      passIn,
   output logic      sdaIn,
   output logic      testErrorSeen
);
   timeunit 1ns;
   timeprecision 1ns;
   // The strap resistor sets the level only while the pass driver is off.
   assign passIn = passOe ? passOut : strapHigh;
   // Open drain: parties only pull low, the pull-up makes the high.
   assign sdaIn = (sdaOe && !sdaOut) ? 1'b0 : 1'b1;
   // Link errors arrive as levels already in the block's clock domain.
   assign testErrorSeen = linkError;
endmodule

/* dv/dcb_chk_sva.sv */
// Port checker for the deserializer configuration block.
module dcb_chk
(
   input wire logic                 clock,
   input wire logic                 srst,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire logic                 powerDown_n,
   input wire logic [1:0]           modeSelect,
   input wire logic [2:0]           busAddressSelect,
   input wire logic                 selfTestEnable,
   input wire logic                 testErrorSeen,
   input wire logic                 passOut,
   input wire logic                 passOe,
   input wire logic                 sdaOut,
   input wire dcb_pkg::dcb_config_type linkConfig,
   input wire logic                 pllEnable,
   input wire logic                 selfTestActive,
   input wire logic [6:0]           busAddress
);
   import dcb_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // An error seen inside self-test is the start of a failed run.
   sequence s_test_error;
      selfTestActive && testErrorSeen;
   endsequence
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   chk_pll_off: assert property
      ((!powerDown_n)[*4] |-> !pllEnable && linkConfig == DCB_CONFIG_RESET)
      else $error("power-down did not stop and clear");
   chk_mode_pin: assert property
      ((powerDown_n && $stable(modeSelect))[*4]
       |-> linkConfig.mode == modeSelect)
      else $error("mode does not follow its pins");
   chk_addr_level: assert property
      ((powerDown_n && $stable(busAddressSelect))[*4]
       |-> busAddress == DCB_ADDR_BASE + 7'(busAddressSelect))
      else $error("bus address does not follow level");
   chk_sda_drain: assert property (!sdaOut)
      else $error("data line driven high");
   chk_test_entry: assert property
      ($rose(selfTestActive) |-> passOut && passOe && $past(selfTestEnable, 3))
      else $error("self-test entry wrong");
   chk_error_drop: assert property (s_test_error |=> !passOut)
      else $error("pass stayed high after error");
   chk_test_exit: assert property
      ((!selfTestEnable)[*4] |-> !selfTestActive && !passOe)
      else $error("self-test still active");
endmodule

bind dcb_deser_config dcb_chk i_chk
(
   .clock, .srst, .hreadyout, .hresp, .powerDown_n, .modeSelect,
   .busAddressSelect, .selfTestEnable, .testErrorSeen, .passOut, .passOe,
   .sdaOut, .linkConfig, .pllEnable, .selfTestActive, .busAddress
);

/* dv/tb_top.sv */
// Self-checking testbench of the deserializer configuration block.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import dcb_pkg::*;
   logic clock = 0, srst = 1, hsel = 0, hwrite = 0, powerDown_n = 1;
   logic outputBitMapSelect = 0, selfTestEnable = 0, sdaPullLow = 0;
   logic strapHigh = 0, linkError = 0;
   logic [1:0] htrans = 0, modeSelect = 0;
   logic [2:0] spreadRangeSelect = 0, busAddressSelect = 0;
   logic [7:0] haddr = 0, lf = 8'h24, cfgSt;
   logic [31:0] hwdata = 0, hrdata;
   logic hreadyout, hresp, passIn, passOut, passOe, sdaIn, sdaOut, sdaOe;
   logic sclSync, sdaSync, sclIn = 1;
   logic testErrorSeen, pllEnable, selfTestActive;
   logic [6:0] busAddress;
   dcb_config_type linkConfig;
   int fail_count = 0, n_compared = 0, ctrlM = 0, eqM = 0;
   always #50 clock = ~clock;
   dcb_deser_config i_dut (.clock, .srst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
      .outputBitMapSelect, .modeSelect, .spreadRangeSelect, .selfTestEnable,
      .powerDown_n, .busAddressSelect, .passIn, .passOut, .passOe,
      .sclIn, .sdaIn, .sdaOut, .sdaOe, .sclSync, .sdaSync,
      .testErrorSeen, .sdaPullLow, .linkConfig, .pllEnable, .selfTestActive,
      .busAddress);
   dcb_board_model i_board (.passOut, .passOe, .sdaOut, .sdaOe, .strapHigh,
      .linkError, .passIn, .sdaIn, .testErrorSeen);
   // Config reordered into the status register's field order.
   assign cfgSt = {linkConfig.eqHighGain, linkConfig.spreadRange,
                   linkConfig.filterOn, linkConfig.mode,
                   linkConfig.mapMsbFirst};
   // Pseudo-random source with a fixed start value.
   function automatic logic [7:0] lfsr();
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      return lf;
   endfunction
   // Expected effective settings; legacy modes never filter.
   function automatic logic [7:0] model();
      int mp, md, f, s, e;
      md = modeSelect;
      mp = ctrlM[0] ? ctrlM[1] : outputBitMapSelect;
      f = md > 1 ? 0 : ctrlM[2] ? ctrlM[3] : md % 2;
      s = ctrlM[4] ? ctrlM[7:5] : spreadRangeSelect;
      e = ctrlM[8] ? ctrlM[9] : eqM;
      return {e[0], s[2:0], f[0], md[1:0], mp[0]};
   endfunction
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e)
      begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // One single word transfer; the slave may stretch either phase.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   // Pins pass two synchroniser stages and a register before they show.
   task automatic check_all;
      logic [31:0] q;
      logic [6:0] a;
      repeat (5) @(posedge clock);
      a = DCB_ADDR_BASE + 7'(busAddressSelect);
      cmp("config", 32'(model()), 32'(cfgSt));
      cmp("address", 32'(a), 32'(busAddress));
      bus(1'b0, DCB_STATUS_OFFSET, 32'h0, q);
      cmp("status", 32'({a, 8'h00, model()}), q);
   endtask
   task automatic print_verdict;
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Cuts the run short if a wait never ends.
   initial
   begin
      repeat (5000) @(posedge clock);
      fail_count++;
      print_verdict();
   end
   initial
   begin
      logic [31:0] q;
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      bus(1'b0, 8'h08, 32'h0, q);
      cmp("unmapped", 32'h0, q);
      // Every mode and map, first from pins, then with random overrides.
      for (int m = 0; m < 16; m++)
      begin
         modeSelect <= m[1:0];
         outputBitMapSelect <= m[2];
         spreadRangeSelect <= 3'(lfsr());
         busAddressSelect <= 3'(lfsr());
         ctrlM = m > 7 ? {lfsr(), lfsr()} & 32'h3FF : 0;
         bus(1'b1, DCB_CTRL_OFFSET, ctrlM, q);
         bus(1'b0, DCB_CTRL_OFFSET, 32'h0, q);
         cmp("ctrl", ctrlM, q);
         check_all();
      end
      // Power-down clears registers; the strap is taken on release.
      strapHigh <= 1'b1;
      powerDown_n <= 1'b0;
      repeat (5) @(posedge clock);
      cmp("pll", 32'h0, 32'(pllEnable));
      bus(1'b0, DCB_CTRL_OFFSET, 32'h0, q);
      cmp("ctrl", 32'h0, q);
      ctrlM = 0;
      eqM = 1;
      powerDown_n <= 1'b1;
      check_all();
      // Self-test passes, then fails on one error and is left.
      selfTestEnable <= 1'b1;
      repeat (5) @(posedge clock);
      cmp("pass", 32'h7, 32'({passOut, passOe, selfTestActive}));
      linkError <= 1'b1;
      @(posedge clock);
      linkError <= 1'b0;
      repeat (3) @(posedge clock);
      cmp("pass", 32'h3, 32'({passOut, passOe, selfTestActive}));
      selfTestEnable <= 1'b0;
      repeat (5) @(posedge clock);
      cmp("pass", 32'h0, 32'({passOut, passOe, selfTestActive}));
      // The data line is only ever pulled low; both bus pins are synced.
      sdaPullLow <= 1'b1;
      sclIn <= 1'b0;
      repeat (5) @(posedge clock);
      cmp("sda", 32'h0, 32'(sdaIn));
      cmp("sync", 32'h0, 32'({sclSync, sdaSync}));
      sdaPullLow <= 1'b0;
      sclIn <= 1'b1;
      repeat (5) @(posedge clock);
      cmp("sda", 32'h1, 32'(sdaIn));
      cmp("sync", 32'h3, 32'({sclSync, sdaSync}));
      print_verdict();
   end
endmodule
